// [rtl/dax_dev.sv]
// controller end: write fifo, per-port slave engine and two-port top
`timescale 1ns/10ps
// ===========================================================
// fifo
module dax_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr[PW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      store[wr_ptr[PW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===========================================================
// one slave port, wholly in its own clock domain
module dax_port (
  dax_if.dev   bus,
  output logic rd_busy
);
  import dax_pkg::*;
  localparam int WF_W = DATA_W + STRB_W + 1;
  // small backing store stands in for the dram behind the port
  logic [DATA_W-1:0]  mem [MEM_WORDS];
  // write side
  logic               aw_held;
  logic [ID_W-1:0]    wr_id;
  logic [ADDR_W-1:0]  wr_addr;
  logic [LEN_W-1:0]   wr_len;
  logic [SIZE_W-1:0]  wr_size;
  logic [BURST_W-1:0] wr_burst;
  logic               wr_err;
  logic               f_valid;
  logic               drain_ready;
  logic               drain;
  logic [WF_W-1:0]    f_data;
  logic               f_last;
  logic [STRB_W-1:0]  f_strb;
  logic [DATA_W-1:0]  f_wdata;
  logic               b_pend;
  logic [ID_W-1:0]    b_id;
  logic [RESP_W-1:0]  b_resp;
  // read side
  dax_rd_state_t      rd_state;
  logic [ID_W-1:0]    rd_id;
  logic [ADDR_W-1:0]  rd_addr;
  logic [ADDR_W-1:0]  rd_next;
  logic [LEN_W-1:0]   rd_len;
  logic [LEN_W-1:0]   rd_cnt;
  logic [SIZE_W-1:0]  rd_size;
  logic [BURST_W-1:0] rd_burst;
  logic [RESP_W-1:0]  rd_resp;
  logic [DATA_W-1:0]  rd_data;
  logic               rd_last;

  // ===========================================================
  // write address: one burst held at a time
  assign bus.awready = !aw_held; // [RULE17]
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin // [RULE2]
    if (!bus.port_reset_n) begin
      aw_held  <= 1'b0;
      wr_id    <= '0;
      wr_addr  <= '0;
      wr_len   <= '0;
      wr_size  <= '0;
      wr_burst <= '0;
      wr_err   <= 1'b0;
    end else if (bus.awvalid && !aw_held) begin // [RULE17]
      aw_held  <= 1'b1;
      wr_id    <= bus.awid; // [RULE16]
      wr_addr  <= bus.awaddr;
      wr_len   <= bus.awlen;
      wr_size  <= bus.awsize;
      wr_burst <= bus.awburst;
      // flag beyond 16 beats is refused rather than half-honoured
      wr_err   <= bus.wr_full_byte_mask_flag && (bus.awlen > ALLSTRB_MAX_LEN); // [RULE21]
    end else if (drain) begin
      wr_addr <= dax_next_addr(wr_addr, wr_size, wr_len, wr_burst); // [RULE13]
      if (f_last) begin
        aw_held <= 1'b0;
      end
    end
  end

  // ===========================================================
  // write data buffered so a stalled drain still back-pressures wready
  dax_fifo #(
    .WIDTH (WF_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk       (bus.aclk),
    .rst_n     (bus.port_reset_n),
    .in_valid  (bus.wvalid),
    .in_ready  (bus.wready), // [RULE11]
    .in_data   ({bus.wlast, bus.wstrb, bus.wdata}),
    .out_valid (f_valid),
    .out_ready (drain_ready),
    .out_data  (f_data)
  );
  assign f_last      = f_data[WF_W-1];
  assign f_strb      = f_data[DATA_W +: STRB_W];
  assign f_wdata     = f_data[DATA_W-1:0];
  // beats wait in the fifo until their burst address is known
  assign drain_ready = aw_held && !b_pend; // [RULE23]
  assign drain       = f_valid && drain_ready;

  always_ff @(posedge bus.aclk) begin
    if (drain && !wr_err) begin
      for (int i = 0; i < STRB_W; i++) begin
        if (f_strb[i]) begin
          mem[dax_mem_idx(wr_addr)][i*8 +: 8] <= f_wdata[i*8 +: 8]; // [RULE9]
        end
      end
    end
  end

  // ===========================================================
  // write response
  assign bus.bvalid = b_pend; // [RULE4]
  assign bus.bid    = b_id;
  assign bus.bresp  = b_resp;
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin
    if (!bus.port_reset_n) begin
      b_pend <= 1'b0;
      b_id   <= '0;
      b_resp <= RESP_OKAY;
    end else if (drain && f_last) begin
      b_pend <= 1'b1; // [RULE23]
      b_id   <= wr_id; // [RULE3]
      b_resp <= wr_err ? RESP_SLVERR : RESP_OKAY; // [RULE8]
    end else if (b_pend && bus.bready) begin
      b_pend <= 1'b0; // [RULE4]
    end
  end

  // ===========================================================
  // read engine: one burst at a time, concurrent with writes
  assign bus.arready = (rd_state == RD_IDLE); // [RULE17]
  assign bus.rvalid  = (rd_state == RD_SEND); // [RULE7]
  assign bus.rdata   = rd_data; // [RULE5]
  assign bus.rid     = rd_id;
  assign bus.rresp   = rd_resp;
  assign bus.rlast   = rd_last;
  assign rd_busy     = (rd_state == RD_SEND);
  assign rd_next     = dax_next_addr(rd_addr, rd_size, rd_len, rd_burst); // [RULE13]
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin // [RULE2]
    if (!bus.port_reset_n) begin
      rd_state <= RD_IDLE;
      rd_id    <= '0;
      rd_addr  <= '0;
      rd_len   <= '0;
      rd_cnt   <= '0;
      rd_size  <= '0;
      rd_burst <= '0;
      rd_resp  <= RESP_OKAY;
      rd_data  <= '0;
      rd_last  <= 1'b0;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (bus.arvalid) begin // [RULE17]
            rd_state <= RD_SEND;
            rd_id    <= bus.arid; // [RULE5]
            rd_addr  <= bus.araddr;
            rd_len   <= bus.arlen;
            rd_cnt   <= bus.arlen;
            rd_size  <= bus.arsize;
            rd_burst <= bus.arburst;
            rd_resp  <= (bus.arburst == BURST_RSVD) ? RESP_SLVERR : RESP_OKAY; // [RULE8]
            rd_data  <= mem[dax_mem_idx(bus.araddr)];
            rd_last  <= (bus.arlen == '0); // [RULE6]
          end
        end
        RD_SEND: begin
          if (bus.rready) begin // [RULE7]
            if (rd_last) begin
              rd_state <= RD_IDLE;
              rd_last  <= 1'b0;
            end else begin
              rd_addr <= rd_next;
              rd_data <= mem[dax_mem_idx(rd_next)];
              rd_cnt  <= rd_cnt - 1'b1;
              rd_last <= (rd_cnt == 8'h01); // [RULE6]
            end
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end
endmodule

// ===========================================================
// two independent ports
module dax_dev (
  dax_if.dev         p0,
  dax_if.dev         p1,
  output logic [1:0] port_busy
);
  dax_port u_port0 ( // [RULE1]
    .bus     (p0),
    .rd_busy (port_busy[0])
  );
  dax_port u_port1 ( // [RULE1]
    .bus     (p1),
    .rd_busy (port_busy[1])
  );
endmodule

// [rtl/dax_host.sv]
// fabric master end of one port
`timescale 1ns/10ps
module dax_host (
  dax_if.host                         bus,
  input  wire logic                   wr_cmd_valid,
  output logic                        wr_cmd_ready,
  input  wire logic [dax_pkg::ID_W-1:0]    wr_cmd_id,
  input  wire logic [dax_pkg::ADDR_W-1:0]  wr_cmd_addr,
  input  wire logic [dax_pkg::LEN_W-1:0]   wr_cmd_len,
  input  wire logic [dax_pkg::SIZE_W-1:0]  wr_cmd_size,
  input  wire logic [dax_pkg::BURST_W-1:0] wr_cmd_burst,
  input  wire logic                   wr_cmd_lock,
  input  wire logic [dax_pkg::CACHE_W-1:0] wr_cmd_cache,
  input  wire logic [dax_pkg::QOS_W-1:0]   wr_cmd_qos,
  input  wire logic                   wr_cmd_autopre,
  input  wire logic                   wr_cmd_allstrb,
  input  wire logic                   wr_cmd_cobuf,
  input  wire logic                   wr_beat_valid,
  output logic                        wr_beat_ready,
  input  wire logic [dax_pkg::DATA_W-1:0]  wr_beat_data,
  input  wire logic [dax_pkg::STRB_W-1:0]  wr_beat_strb,
  output logic                        wr_done_valid,
  input  wire logic                   wr_done_ready,
  output logic [dax_pkg::ID_W-1:0]    wr_done_id,
  output logic [dax_pkg::RESP_W-1:0]  wr_done_resp,
  input  wire logic                   rd_cmd_valid,
  output logic                        rd_cmd_ready,
  input  wire logic [dax_pkg::ID_W-1:0]    rd_cmd_id,
  input  wire logic [dax_pkg::ADDR_W-1:0]  rd_cmd_addr,
  input  wire logic [dax_pkg::LEN_W-1:0]   rd_cmd_len,
  input  wire logic [dax_pkg::SIZE_W-1:0]  rd_cmd_size,
  input  wire logic [dax_pkg::BURST_W-1:0] rd_cmd_burst,
  input  wire logic                   rd_cmd_lock,
  input  wire logic [dax_pkg::QOS_W-1:0]   rd_cmd_qos,
  input  wire logic                   rd_cmd_autopre,
  output logic                        rd_beat_valid,
  input  wire logic                   rd_beat_ready,
  output logic [dax_pkg::DATA_W-1:0]  rd_beat_data,
  output logic [dax_pkg::ID_W-1:0]    rd_beat_id,
  output logic [dax_pkg::RESP_W-1:0]  rd_beat_resp,
  output logic                        rd_beat_last
);
  import dax_pkg::*;
  dax_hw_state_t    hw_state;
  logic             aw_pend;
  logic             sent_all;
  logic [LEN_W-1:0] beats_left;
  logic             w_full;
  logic             w_take;
  logic             ar_pend;

  // ===========================================================
  // write command and address channel
  assign wr_cmd_ready = (hw_state == HW_IDLE);
  assign bus.awvalid  = aw_pend;
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin // [RULE2]
    if (!bus.port_reset_n) begin
      hw_state                       <= HW_IDLE;
      aw_pend                        <= 1'b0;
      bus.awid                       <= '0;
      bus.awaddr                     <= '0;
      bus.awlen                      <= '0;
      bus.awsize                     <= '0;
      bus.awburst                    <= '0;
      bus.awlock                     <= 1'b0;
      bus.awcache                    <= '0;
      bus.wr_qos_ident               <= '0;
      bus.wr_autoprecharge_req       <= 1'b0;
      bus.wr_full_byte_mask_flag     <= 1'b0;
      bus.wr_coherent_bufferable_sel <= 1'b0;
    end else begin
      case (hw_state)
        HW_IDLE: begin
          if (wr_cmd_valid) begin
            hw_state                       <= HW_BUSY;
            aw_pend                        <= 1'b1;
            bus.awid                       <= wr_cmd_id; // [RULE16]
            bus.awaddr                     <= wr_cmd_addr; // [RULE12]
            bus.awlen                      <= wr_cmd_len; // [RULE14]
            bus.awsize                     <= wr_cmd_size; // [RULE15]
            bus.awburst                    <= wr_cmd_burst;
            bus.awlock                     <= wr_cmd_lock; // [RULE18]
            bus.awcache                    <= wr_cmd_cache; // [RULE20]
            bus.wr_qos_ident               <= wr_cmd_qos; // [RULE19]
            bus.wr_autoprecharge_req       <= wr_cmd_autopre; // [RULE19]
            // long bursts drop the hint instead of being refused
            bus.wr_full_byte_mask_flag     <= wr_cmd_allstrb &&
                                              (wr_cmd_len <= ALLSTRB_MAX_LEN); // [RULE21]
            bus.wr_coherent_bufferable_sel <= wr_cmd_cobuf; // [RULE22]
          end
        end
        HW_BUSY: begin
          if (aw_pend && bus.awready) begin // [RULE17]
            aw_pend <= 1'b0;
          end
          if (sent_all && !w_full && !(aw_pend && !bus.awready)) begin
            hw_state <= HW_IDLE;
          end
        end
        default: begin
          hw_state <= HW_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // write data: one register stage, refilled in the cycle it empties
  assign wr_beat_ready = (hw_state == HW_BUSY) && !sent_all && (!w_full || bus.wready);
  assign w_take        = wr_beat_valid && wr_beat_ready;
  assign bus.wvalid    = w_full;
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin
    if (!bus.port_reset_n) begin
      w_full     <= 1'b0;
      sent_all   <= 1'b0;
      beats_left <= '0;
      bus.wdata  <= '0;
      bus.wstrb  <= '0;
      bus.wlast  <= 1'b0;
    end else begin
      if (hw_state == HW_IDLE && wr_cmd_valid) begin
        beats_left <= wr_cmd_len;
        sent_all   <= 1'b0;
      end else if (w_take) begin
        bus.wdata  <= wr_beat_data; // [RULE9]
        bus.wstrb  <= wr_beat_strb; // [RULE9]
        bus.wlast  <= (beats_left == '0); // [RULE10]
        beats_left <= beats_left - 1'b1;
        sent_all   <= (beats_left == '0);
      end
      if (w_take) begin
        w_full <= 1'b1;
      end else if (bus.wready) begin
        w_full <= 1'b0; // [RULE11]
      end
    end
  end

  // ===========================================================
  // write response passes straight to the user
  assign wr_done_valid = bus.bvalid;
  assign bus.bready    = wr_done_ready; // [RULE4]
  assign wr_done_id    = bus.bid;
  assign wr_done_resp  = bus.bresp;

  // ===========================================================
  // read address channel and read data pass-through
  assign rd_cmd_ready = !ar_pend;
  assign bus.arvalid  = ar_pend;
  always_ff @(posedge bus.aclk or negedge bus.port_reset_n) begin
    if (!bus.port_reset_n) begin
      ar_pend                  <= 1'b0;
      bus.arid                 <= '0;
      bus.araddr               <= '0;
      bus.arlen                <= '0;
      bus.arsize               <= '0;
      bus.arburst              <= '0;
      bus.arlock               <= 1'b0;
      bus.rd_qos_ident         <= '0;
      bus.rd_autoprecharge_req <= 1'b0;
    end else if (!ar_pend && rd_cmd_valid) begin
      ar_pend                  <= 1'b1;
      bus.arid                 <= rd_cmd_id; // [RULE16]
      bus.araddr               <= rd_cmd_addr; // [RULE12]
      bus.arlen                <= rd_cmd_len; // [RULE14]
      bus.arsize               <= rd_cmd_size; // [RULE15]
      bus.arburst              <= rd_cmd_burst;
      bus.arlock               <= rd_cmd_lock; // [RULE18]
      bus.rd_qos_ident         <= rd_cmd_qos; // [RULE19]
      bus.rd_autoprecharge_req <= rd_cmd_autopre; // [RULE19]
    end else if (ar_pend && bus.arready) begin
      ar_pend <= 1'b0; // [RULE17]
    end
  end
  assign rd_beat_valid = bus.rvalid;
  assign bus.rready    = rd_beat_ready; // [RULE7]
  assign rd_beat_data  = bus.rdata;
  assign rd_beat_id    = bus.rid;
  assign rd_beat_resp  = bus.rresp;
  assign rd_beat_last  = bus.rlast;
endmodule

// [rtl/dax_if.sv]
// one port link: five channels plus sideband qualifiers
`timescale 1ns/10ps
interface dax_if (
  input wire logic aclk,
  input wire logic port_reset_n
);
  logic [dax_pkg::ID_W-1:0]    awid;
  logic [dax_pkg::ADDR_W-1:0]  awaddr;
  logic [dax_pkg::LEN_W-1:0]   awlen;
  logic [dax_pkg::SIZE_W-1:0]  awsize;
  logic [dax_pkg::BURST_W-1:0] awburst;
  logic                        awlock;
  logic [dax_pkg::CACHE_W-1:0] awcache;
  logic [dax_pkg::QOS_W-1:0]   wr_qos_ident;
  logic                        wr_autoprecharge_req;
  logic                        wr_full_byte_mask_flag;
  logic                        wr_coherent_bufferable_sel;
  logic                        awvalid;
  logic                        awready;
  logic [dax_pkg::DATA_W-1:0]  wdata;
  logic [dax_pkg::STRB_W-1:0]  wstrb;
  logic                        wlast;
  logic                        wvalid;
  logic                        wready;
  logic [dax_pkg::ID_W-1:0]    bid;
  logic [dax_pkg::RESP_W-1:0]  bresp;
  logic                        bvalid;
  logic                        bready;
  logic [dax_pkg::ID_W-1:0]    arid;
  logic [dax_pkg::ADDR_W-1:0]  araddr;
  logic [dax_pkg::LEN_W-1:0]   arlen;
  logic [dax_pkg::SIZE_W-1:0]  arsize;
  logic [dax_pkg::BURST_W-1:0] arburst;
  logic                        arlock;
  logic [dax_pkg::QOS_W-1:0]   rd_qos_ident;
  logic                        rd_autoprecharge_req;
  logic                        arvalid;
  logic                        arready;
  logic [dax_pkg::DATA_W-1:0]  rdata;
  logic [dax_pkg::ID_W-1:0]    rid;
  logic [dax_pkg::RESP_W-1:0]  rresp;
  logic                        rlast;
  logic                        rvalid;
  logic                        rready;
  modport dev (
    input  aclk, port_reset_n,
    input  awid, awaddr, awlen, awsize, awburst, awlock, awcache, wr_qos_ident,
    input  wr_autoprecharge_req, wr_full_byte_mask_flag, wr_coherent_bufferable_sel, awvalid,
    output awready,
    input  wdata, wstrb, wlast, wvalid,
    output wready,
    output bid, bresp, bvalid,
    input  bready,
    input  arid, araddr, arlen, arsize, arburst, arlock, rd_qos_ident, rd_autoprecharge_req,
    input  arvalid,
    output arready,
    output rdata, rid, rresp, rlast, rvalid,
    input  rready
  );
  modport host (
    input  aclk, port_reset_n,
    output awid, awaddr, awlen, awsize, awburst, awlock, awcache, wr_qos_ident,
    output wr_autoprecharge_req, wr_full_byte_mask_flag, wr_coherent_bufferable_sel, awvalid,
    input  awready,
    output wdata, wstrb, wlast, wvalid,
    input  wready,
    input  bid, bresp, bvalid,
    output bready,
    output arid, araddr, arlen, arsize, arburst, arlock, rd_qos_ident, rd_autoprecharge_req,
    output arvalid,
    input  arready,
    input  rdata, rid, rresp, rlast, rvalid,
    output rready
  );
endinterface

// [rtl/dax_pkg.sv]
// constants, types and address arithmetic shared by both ends of the port link
//
// Overview of operation
// RULE1 - two independent full-duplex slave ports, 0 and 1
// RULE2 - each port own clock, own low reset
// RULE3 - write response returns the write's 6-bit tag
// RULE4 - response moves when valid and ready both high
// RULE5 - 512-bit read beats tagged with request identifier
// RULE6 - read-last high only on final beat
// RULE7 - read beat moves when valid and ready high
// RULE8 - 2-bit status on read beats and responses
// RULE9 - master sends 512-bit data, 64 byte strobes
// RULE10 - master raises write-last on final beat only
// RULE11 - write beat moves when valid and ready high
// RULE12 - master gives 33-bit start byte address
// RULE13 - burst 01 increments, 10 wraps addresses
// RULE14 - master gives 8-bit burst length
// RULE15 - master gives 3-bit transfer size
// RULE16 - every request carries 6-bit master identifier
// RULE17 - request taken when valid and ready high
// RULE18 - every request carries a lock qualifier
// RULE19 - requests carry qos and auto-precharge flag
// RULE20 - writes carry 4-bit memory type
// RULE21 - all-strobes flag limited to 16 beats
// RULE22 - writes carry coherent bufferable select bit
// RULE23 - response only after request and last beat
package dax_pkg;
  // ===========================================================
  // widths
  localparam int ID_W    = 6;
  localparam int ADDR_W  = 33;
  localparam int LEN_W   = 8;
  localparam int SIZE_W  = 3;
  localparam int BURST_W = 2;
  localparam int DATA_W  = 512;
  localparam int STRB_W  = 64;
  localparam int RESP_W  = 2;
  localparam int CACHE_W = 4;
  localparam int QOS_W   = 4;
  // ===========================================================
  // encodings and limits
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_INCR  = 2'h1;
  localparam logic [BURST_W-1:0] BURST_WRAP  = 2'h2;
  localparam logic [BURST_W-1:0] BURST_RSVD  = 2'h3;
  localparam logic [RESP_W-1:0]  RESP_OKAY   = 2'h0;
  localparam logic [RESP_W-1:0]  RESP_SLVERR = 2'h2;
  localparam logic [LEN_W-1:0]   ALLSTRB_MAX_LEN = 8'h0f;
  localparam int FIFO_DEPTH  = 8;
  localparam int MEM_WORDS   = 16;
  localparam int MEM_IDX_LSB = 6;
  localparam int MEM_IDX_W   = 4;
  // ===========================================================
  // state types
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_SEND = 2'b10} dax_rd_state_t;
  typedef enum logic [1:0] {HW_IDLE = 2'b01, HW_BUSY = 2'b10} dax_hw_state_t;
  // ===========================================================
  // address of the following beat of a burst
  function automatic logic [ADDR_W-1:0] dax_next_addr(
    input logic [ADDR_W-1:0]  addr,
    input logic [SIZE_W-1:0]  size,
    input logic [LEN_W-1:0]   len,
    input logic [BURST_W-1:0] burst
  );
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] span;
    step = ADDR_W'(1) << size;
    span = (ADDR_W'(len) + ADDR_W'(1)) << size;
    if (burst == BURST_INCR) begin
      dax_next_addr = addr + step;
    end else if (burst == BURST_WRAP) begin
      dax_next_addr = (addr & ~(span - ADDR_W'(1))) | ((addr + step) & (span - ADDR_W'(1)));
    end else begin
      dax_next_addr = addr;
    end
  endfunction
  function automatic logic [MEM_IDX_W-1:0] dax_mem_idx(input logic [ADDR_W-1:0] addr);
    dax_mem_idx = addr[MEM_IDX_LSB +: MEM_IDX_W];
  endfunction
endpackage

// [test/dax_props.sv]
// concurrent checks on one port link
`timescale 1ns/10ps
module dax_props (
  input wire logic                     aclk, port_reset_n,
  input wire logic                     awvalid, awready, bvalid, bready,
  input wire logic                     arvalid, arready, rvalid, rready, rlast,
  input wire logic [dax_pkg::ID_W-1:0] awid, bid, arid, rid
);
  // ===========================================================
  // tag of the write in flight, one burst at a time
  logic [dax_pkg::ID_W-1:0] tag;
  logic [1:0]               got;
  always_ff @(posedge aclk or negedge port_reset_n) begin
    if (!port_reset_n) begin
      tag <= '0;
      got <= '0;
    end else begin
      if (awvalid && awready) begin
        tag <= awid;
      end
      got <= got + 2'(awvalid && awready) - 2'(bvalid && bready);
    end
  end
  // ===========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!port_reset_n);
  resp_tag_a: assert property ($rose(bvalid) |-> bid == tag)
    else $error("bid not the write tag");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bid))
    else $error("response dropped early");
  resp_after_a: assert property ($rose(bvalid) |-> got)
    else $error("response without request");
  rd_tag_a: assert property (arvalid && arready |=> rvalid && rid == $past(arid))
    else $error("read tag or start wrong");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rlast, rid}))
    else $error("read beat not held");
  rd_end_a: assert property (rvalid && rready && rlast |=> !rvalid && arready)
    else $error("beat after last");
  aw_take_a: assert property (awvalid && awready |=> !awready)
    else $error("second write request taken");
  ar_take_a: assert property (arvalid && arready |=> !arready)
    else $error("second read request taken");
endmodule

// [test/dram_ctrl_axi_slave_ports_tb_top.sv]
// bench: two host ends against the two-port controller end
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module dram_ctrl_axi_slave_ports_tb_top;
  logic         clk = 1'b0, rst = 1'b1, wv, bv, dr, rv, rr, as;
  logic [5:0]   wid, rid, did[2], rido[2];
  logic [32:0]  wa, ra;
  logic [7:0]   wl, rl;
  logic [1:0]   wb, rb, drs[2], rrs[2], busy;
  logic [31:0]  sb;
  logic [63:0]  bs;
  logic [511:0] bd, rdo[2], mem[16];
  logic         cr[2], br[2], dv[2], rc[2], rvv[2], rla[2];
  int           mismatches = 0, n_compared = 0, cyc = 0;
  always #2.5 clk = ~clk;
  dax_if ifc[2] (.aclk(clk), .port_reset_n(~rst));
  dax_dev u_dax_dev (.p0(ifc[0]), .p1(ifc[1]), .port_busy(busy));
  dax_props u_dax_props (.aclk(clk), .port_reset_n(ifc[0].port_reset_n),
    .awvalid(ifc[0].awvalid), .awready(ifc[0].awready), .bvalid(ifc[0].bvalid),
    .bready(ifc[0].bready), .arvalid(ifc[0].arvalid), .arready(ifc[0].arready),
    .rvalid(ifc[0].rvalid), .rready(ifc[0].rready), .rlast(ifc[0].rlast),
    .awid(ifc[0].awid), .bid(ifc[0].bid), .arid(ifc[0].arid), .rid(ifc[0].rid));
  // ===========================================================
  // both ports get the same traffic and must answer alike
  for (genvar g = 0; g < 2; g++) begin : gp
    dax_host u_dax_host (.bus(ifc[g]), .wr_cmd_valid(wv), .wr_cmd_ready(cr[g]),
      .wr_cmd_id(wid), .wr_cmd_addr(wa), .wr_cmd_len(wl), .wr_cmd_size(3'h6),
      .wr_cmd_burst(wb), .wr_cmd_lock(sb[0]), .wr_cmd_cache(sb[4:1]), .wr_cmd_qos(sb[8:5]),
      .wr_cmd_autopre(sb[9]), .wr_cmd_allstrb(as), .wr_cmd_cobuf(sb[10]),
      .wr_beat_valid(bv), .wr_beat_ready(br[g]), .wr_beat_data(bd), .wr_beat_strb(bs),
      .wr_done_valid(dv[g]), .wr_done_ready(dr), .wr_done_id(did[g]), .wr_done_resp(drs[g]),
      .rd_cmd_valid(rv), .rd_cmd_ready(rc[g]), .rd_cmd_id(rid), .rd_cmd_addr(ra),
      .rd_cmd_len(rl), .rd_cmd_size(3'h6), .rd_cmd_burst(rb), .rd_cmd_lock(sb[11]),
      .rd_cmd_qos(sb[15:12]), .rd_cmd_autopre(sb[16]), .rd_beat_valid(rvv[g]),
      .rd_beat_ready(rr), .rd_beat_data(rdo[g]), .rd_beat_id(rido[g]),
      .rd_beat_resp(rrs[g]), .rd_beat_last(rla[g]));
  end
  // ===========================================================
  // tasks
  function automatic logic [32:0] at(logic [32:0] a, logic [7:0] l, logic [1:0] b, int k);
    logic [32:0] m;
    m = ({25'h0, l} + 33'h1) * 33'h40 - 33'h1;
    if (b == 2'h1) return a + 33'(k) * 33'h40;
    if (b == 2'h2) return (a & ~m) | ((a + 33'(k) * 33'h40) & m);
    return a;
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ready lines toggle at random so both sides see stalls
  task automatic tick();
    @(posedge clk);
    #1;
    dr = 1'($urandom);
    rr = 1'($urandom);
    cyc++;
    if (cyc > 30000) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wr(logic [7:0] l, logic [1:0] b, logic f);
    logic [32:0] x;
    wid = 6'($urandom); wa = 33'($urandom); wl = l; wb = b; as = f; sb = $urandom; wv = 1'b1;
    while (!cr[0]) tick();
    tick();
    wv = 1'b0;
    for (int k = 0; k <= l; k++) begin
      bd = {16{$urandom}};
      bs = f ? '1 : {$urandom, $urandom};
      bv = 1'b1;
      while (!br[0]) tick();
      x = at(wa, l, b, k);
      for (int i = 0; i < 64; i++) if (bs[i]) mem[x[9:6]][8*i +: 8] = bd[8*i +: 8];
      tick();
    end
    bv = 1'b0;
    while (!(dv[0] && dr)) tick();
    for (int p = 0; p < 2; p++) begin
      `CHK("bid", wid, did[p])
      `CHK("bresp", 2'h0, drs[p])
    end
    tick();
  endtask
  task automatic rd(logic [7:0] l, logic [1:0] b);
    logic [32:0] x;
    rid = 6'($urandom); ra = 33'($urandom); rl = l; rb = b; sb = $urandom; rv = 1'b1;
    while (!rc[0]) tick();
    tick();
    rv = 1'b0;
    for (int k = 0; k <= l; k++) begin
      while (!(rvv[0] && rr)) tick();
      x = at(ra, l, b, k);
      `CHK("busy", 2'h3, busy)
      for (int p = 0; p < 2; p++) begin
        `CHK("rdata", mem[x[9:6]], rdo[p])
        `CHK("rid", rid, rido[p])
        `CHK("rresp", (b == 2'h3) ? 2'h2 : 2'h0, rrs[p])
        `CHK("rlast", k == l, rla[p])
      end
      tick();
    end
  endtask
  // ===========================================================
  // main sequence: fill every word first, memory powers up unknown
  initial begin
    {wv, bv, dr, rv, rr, as, wid, rid, wa, ra, wl, rl, wb, rb, sb, bd, bs} = '0;
    void'($urandom(32'ha82e84f4));
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    tick();
    wr(8'hf, 2'h1, 1'b1);
    wr(8'h10, 2'h1, 1'b1);
    $display("test fill done");
    for (int t = 0; t < 24; t++) begin
      rd(8'((1 << ($urandom % 5)) - 1), 2'(t));
      wr(8'((1 << ($urandom % 4)) - 1), 2'(t), 1'b0);
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule
